// >>> src/ext_bus_area_cycle_timing.v
/*
 * external bus chip-select area cycle sequencer with its settings
 * registers: address delay, strobe to select hold, write recovery and
 * split of writes wider than the bus, plus bus share control.
 * assumes a plain register port on ref_clk_in, an internal access
 * request from the same clock domain and an external bus request pin.
 */
// Behaviour
// - hold enable adds strobe-to-select hold cycle
// - access type top bit zero selects normal
// - delay enable adds address-to-select cycle
// - recovery field zero means no recovery
// - split writes of normal type hold only on last piece when delay is off and recovery on
// - reads always get enabled hold cycle
// - timing control is write-only, written whole
`timescale 1ns/1ps
`include "ext_bus_timing_defines.vh"
module ext_bus_area_cycle_timing (
  // clock and reset
  input  wire                 ref_clk_in,
  input  wire                 nrst_in,
  // register port
  input  wire [`ADDR_W-1:0]   reg_addr_in,
  input  wire [15:0]          reg_wdata_in,
  input  wire                 reg_wr_in,
  input  wire                 reg_rd_in,
  output reg  [15:0]          reg_rdata_out,
  // internal access request
  input  wire                 acc_req_in,
  input  wire                 acc_write_in,
  input  wire                 acc_wide_in,
  output reg                  acc_done_out,
  // external bus
  output reg                  addr_valid_out,
  output reg                  sel_n_out,
  output reg                  rd_n_out,
  output reg                  wr_n_out,
  output reg                  piece_out,
  // bus sharing
  input  wire                 bus_req_pin_in,
  output reg                  bus_grant_out
);

  // ***********************************************************************
  // settings registers
  // ***********************************************************************
  reg [7:0]  term_ctrl_ff;     // terminal and timing control, write only
  reg [15:0] area_wait_ff;     // area wait settings
  reg [15:0] area_access_ff;   // area access type
  reg [7:0]  port8_func_ff;    // port 8 function select

  wire wr_term   = reg_wr_in && (reg_addr_in == `REG_TERM_CTRL);
  wire wr_wait   = reg_wr_in && (reg_addr_in == `REG_AREA_WAIT);
  wire wr_access = reg_wr_in && (reg_addr_in == `REG_AREA_ACCESS);
  wire wr_port8  = reg_wr_in && (reg_addr_in == `REG_PORT8_FUNC);

  // whole-register writes only; term control has no readback to merge from
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      term_ctrl_ff   <= `RST_TERM_CTRL;
      area_wait_ff   <= `RST_AREA_WAIT;
      area_access_ff <= `RST_AREA_ACCESS;
      port8_func_ff  <= `RST_PORT8_FUNC;
    end else begin
      if (wr_term) begin
        term_ctrl_ff <= reg_wdata_in[7:0];
      end
      if (wr_wait) begin
        area_wait_ff <= reg_wdata_in;
      end
      if (wr_access) begin
        area_access_ff <= reg_wdata_in;
      end
      if (wr_port8) begin
        port8_func_ff <= reg_wdata_in[7:0];
      end
    end
  end

  // ***********************************************************************
  // decoded settings
  // ***********************************************************************
  wire hold_extension_enable       = area_wait_ff[`BIT_HOLD_EXT];
  wire addr_to_select_delay_enable = area_wait_ff[`BIT_ADDR_DLY];
  wire write_recovery_hi           = area_wait_ff[`BIT_WREC_HI];
  wire write_recovery_lo           = area_wait_ff[`BIT_WREC_LO];
  wire access_type_bit3            = area_access_ff[`BIT_ACCESS_TYPE_BIT3];
  wire bus_share_enable            = term_ctrl_ff[`BIT_SHARE_EN];
  wire bus_request_pin_enable      = port8_func_ff[`BIT_BREQ_PIN];
  // normal memory/io type only; other codes are not supported
  wire normal_type = !access_type_bit3;
  wire [1:0] wrec  = {write_recovery_hi, write_recovery_lo};
  wire rec_on      = (wrec != 2'h0);
  // the documented quirk: hold dropped on early split-write pieces
  wire quirk = hold_extension_enable && normal_type &&
               !addr_to_select_delay_enable && rec_on;
  // sequencer state and recovery status, declared here for the status word
  reg  [2:0]  state_ff;      // sequencer state
  wire        rec_busy;      // recovery still counting
  wire [15:0] status_word = {11'h000, bus_grant_out, rec_busy,
                             state_ff};

  // ***********************************************************************
  // register read port, data one cycle after the strobe
  // ***********************************************************************
  reg [15:0] nxt_rdata;
  always @* begin
    case (reg_addr_in)
      `REG_AREA_WAIT:   nxt_rdata = area_wait_ff;
      `REG_AREA_ACCESS: nxt_rdata = area_access_ff;
      `REG_PORT8_FUNC:  nxt_rdata = {8'h00, port8_func_ff};
      `REG_STATUS:      nxt_rdata = status_word;
      default:          nxt_rdata = 16'h0000;   // incl. write-only
    endcase
  end

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= nxt_rdata;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // ***********************************************************************
  // bus share request pin
  // ***********************************************************************
  wire breq_sync;   // synchronised request level
  pin_sync u_breq_sync (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .pin_in     (bus_req_pin_in),
    .sync_out   (breq_sync)
  );

  // grant only when sharing and pin function both on; clearing the pin
  // function first lets a pending grant drop cleanly
  wire share_req = bus_share_enable && bus_request_pin_enable &&
                   breq_sync;
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_grant_out <= 1'b0;
    end else if (share_req && (state_ff == `ST_IDLE)) begin
      bus_grant_out <= 1'b1;
    end else if (!share_req) begin
      bus_grant_out <= 1'b0;
    end
  end

  // ***********************************************************************
  // recovery counter
  // ***********************************************************************
  reg  rec_load;
  cycle_counter u_rec_cnt (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .load_in    (rec_load),
    .count_in   (wrec),
    .busy_out   (rec_busy)
  );

  // ***********************************************************************
  // cycle sequencer
  // ***********************************************************************
  reg       write_ff;   // current access is a write
  reg       last_ff;    // current piece is the final one
  reg [2:0] nxt_state;
  reg       nxt_write;
  reg       nxt_last;
  reg       want_hold;

  always @* begin
    // hold on reads whenever hold is enabled; on writes, not on non-final pieces if quirk
    want_hold = hold_extension_enable &&
                (!write_ff || last_ff || !quirk);
  end

  always @* begin
    nxt_state = state_ff;
    nxt_write = write_ff;
    nxt_last  = last_ff;
    rec_load  = 1'b0;
    case (state_ff)
      `ST_IDLE: begin
        if (acc_req_in && !bus_grant_out && !rec_busy) begin
          nxt_write = acc_write_in;
          nxt_last  = !(acc_write_in && acc_wide_in);
          // optional address-to-select delay
          nxt_state = addr_to_select_delay_enable ?
                      `ST_ADDR : `ST_STRB;
        end
      end
      `ST_ADDR: begin
        nxt_state = `ST_STRB;
      end
      `ST_STRB: begin
        if (want_hold) begin
          nxt_state = `ST_HOLD;
        end else begin
          nxt_state = `ST_RECV;
        end
      end
      `ST_HOLD: begin
        nxt_state = `ST_RECV;
      end
      `ST_RECV: begin
        // recovery after each written piece when enabled
        // load once on leaving; reloading while stalled would never drain
        rec_load = write_ff && rec_on && !rec_busy;
        if (last_ff) begin
          nxt_state = `ST_IDLE;
        end else begin
          nxt_last  = 1'b1;
          nxt_state = addr_to_select_delay_enable ? `ST_ADDR : `ST_STRB;
        end
      end
      default: begin
        nxt_state = `ST_IDLE;
      end
    endcase
  end

  // recovery stall: stay in recv until the counter loaded by the previous piece drains
  wire advance = !((state_ff == `ST_RECV) && rec_busy);

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= `ST_IDLE;
      write_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else if (advance) begin
      state_ff <= nxt_state;
      write_ff <= nxt_write;
      last_ff  <= nxt_last;
    end
  end

  // ***********************************************************************
  // registered bus outputs
  // ***********************************************************************
  wire go_busy = advance && (nxt_state != `ST_IDLE);
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_valid_out <= 1'b0;
      sel_n_out      <= 1'b1;
      rd_n_out       <= 1'b1;
      wr_n_out       <= 1'b1;
      piece_out      <= 1'b0;
      acc_done_out   <= 1'b0;
    end else begin
      addr_valid_out <= go_busy ? (nxt_state != `ST_RECV) :
                        (state_ff != `ST_IDLE) &&
                        (state_ff != `ST_RECV);
      // select is held through the hold cycle, dropped in recovery
      sel_n_out <= !(advance ? (nxt_state == `ST_STRB ||
                                nxt_state == `ST_HOLD)
                             : (state_ff == `ST_STRB ||
                                state_ff == `ST_HOLD));
      rd_n_out  <= !(advance && nxt_state == `ST_STRB && !nxt_write);
      wr_n_out  <= !(advance && nxt_state == `ST_STRB && nxt_write);
      piece_out <= nxt_last;
      acc_done_out <= advance && (state_ff == `ST_RECV) && last_ff;
    end
  end
endmodule // ext_bus_area_cycle_timing

// >>> src/ext_bus_timing_defines.vh
/*
 * constants for the external bus area timing block: register indices,
 * field positions, reset values and state codes.
 * assumes it is included once per file by its bare name.
 */
`ifndef EXT_BUS_TIMING_DEFINES_VH
`define EXT_BUS_TIMING_DEFINES_VH

// ***********************************************************************
// register map (byte addresses on the plain register port)
// ***********************************************************************
`define ADDR_W              12
`define REG_TERM_CTRL       12'h683
`define REG_AREA_WAIT       12'h010
`define REG_AREA_ACCESS     12'h014
`define REG_PORT8_FUNC      12'h018
`define REG_STATUS          12'h01C

// ***********************************************************************
// reset values
// ***********************************************************************
`define RST_TERM_CTRL       8'h00
`define RST_AREA_WAIT       16'h0000
`define RST_AREA_ACCESS     16'h0000
`define RST_PORT8_FUNC      8'h00

// ***********************************************************************
// field positions
// ***********************************************************************
`define BIT_HOLD_EXT        0
`define BIT_ADDR_DLY        2
`define BIT_WREC_LO         4
`define BIT_WREC_HI         5
`define BIT_ACCESS_TYPE_BIT3           3
`define BIT_SHARE_EN        7
`define BIT_BREQ_PIN        2

// ***********************************************************************
// sequencer state codes
// ***********************************************************************
`define ST_IDLE             3'h0
`define ST_ADDR             3'h1
`define ST_STRB             3'h2
`define ST_HOLD             3'h3
`define ST_RECV             3'h4

`endif

// >>> src/cycle_counter.v
/*
 * down counter used for recovery cycles: loads a count, ticks to zero.
 * assumes a single clock and asynchronous active low reset.
 */
`timescale 1ns/1ps
module cycle_counter (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  // control
  input  wire       load_in,
  input  wire [1:0] count_in,
  // status
  output wire       busy_out
);
  reg [1:0] cnt_ff;   // remaining cycles

  // ***********************************************************************
  // counter
  // ***********************************************************************
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= 2'h0;
    end else if (load_in) begin
      cnt_ff <= count_in;
    end else if (cnt_ff != 2'h0) begin
      cnt_ff <= cnt_ff - 2'h1;
    end
  end

  assign busy_out = (cnt_ff != 2'h0);
endmodule // cycle_counter

// >>> src/pin_sync.v
/*
 * two flop synchroniser for a pin level.
 * assumes the pin is asynchronous to ref_clk_in.
 */
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire ref_clk_in,
  input  wire nrst_in,
  // pin and synchronised level
  input  wire pin_in,
  output reg  sync_out
);
  reg meta_ff;   // first stage, read only by the second

  // ***********************************************************************
  // two stages
  // ***********************************************************************
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= pin_in;
      sync_out <= meta_ff;
    end
  end
endmodule // pin_sync

// >>> dv/ext_bus_mem_model.sv
/* passive model of the memory or io device on the area bus: measures
   address delay, select hold and piece count of each access.
   assumes registered bus outputs on ref_clk_in. */
`timescale 1ns/1ps
module ext_bus_mem_model (
  // clock, reset and measurement clear
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire       clr_in,
  // bus seen from the device
  input  wire       addr_valid_in,
  input  wire       sel_n_in,
  input  wire       rd_n_in,
  input  wire       wr_n_in,
  // measurements
  output reg  [3:0] hold_first_out,
  output reg  [3:0] hold_last_out,
  output reg  [3:0] dly_first_out,
  output reg  [3:0] piece_cnt_out
);
  reg [3:0] hc_ff;    // hold cycles after a strobe
  reg [3:0] dc_ff;    // address out, select idle
  reg       after_ff; // a strobe has ended
  reg       sel_ff;   // last select level
  // ***************************************************************
  // measuring process
  // ***************************************************************
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in || clr_in) begin
      {hc_ff, dc_ff, after_ff} <= 9'h000;
      {hold_first_out, hold_last_out} <= 8'h00;
      {dly_first_out, piece_cnt_out} <= 8'h00;
      sel_ff <= 1'b1;
    end else begin
      sel_ff <= sel_n_in;
      // cleared when address drops so a gap never counts
      dc_ff <= (addr_valid_in && sel_n_in) ? dc_ff + 4'h1 : 4'h0;
      if (sel_ff && !sel_n_in && piece_cnt_out == 4'h0) begin
        dly_first_out <= dc_ff;
      end
      if (!rd_n_in || !wr_n_in) begin
        after_ff      <= 1'b1;
        hc_ff         <= 4'h0;
        piece_cnt_out <= piece_cnt_out + 4'h1;
      end else if (after_ff && !sel_n_in) begin
        hc_ff <= hc_ff + 4'h1;
      end else if (after_ff) begin
        // select released: the hold of this piece is known
        after_ff      <= 1'b0;
        hold_last_out <= hc_ff;
        if (piece_cnt_out == 4'h1) begin
          hold_first_out <= hc_ff;
        end
      end
    end
  end
endmodule // ext_bus_mem_model

// >>> dv/ext_bus_timing_sva.sv
/* assertions on the area cycle timing block ports.
   assumes binding to the top module; settings tracked from writes. */
`timescale 1ns/1ps
`include "ext_bus_timing_defines.vh"
module ext_bus_timing_sva (
  // clock and reset
  input wire               ref_clk_in,
  input wire               nrst_in,
  // register port
  input wire [`ADDR_W-1:0] reg_addr_in,
  input wire [15:0]        reg_wdata_in,
  input wire               reg_wr_in,
  input wire               reg_rd_in,
  input wire [15:0]        reg_rdata_out,
  // external bus
  input wire               addr_valid_out,
  input wire               sel_n_out,
  input wire               rd_n_out,
  input wire               wr_n_out,
  input wire               piece_out,
  input wire               bus_grant_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  reg [5:0] wait_ff;  // shadow of wait settings
  reg [3:0] type_ff;  // shadow of access type
  reg       share_ff; // shadow of share enable
  reg       wr_ff;    // last strobe was a write
  reg       fin_ff;   // last strobe was a final piece
  wire split_w = wait_ff[0] && !wait_ff[2] && wait_ff[5:4] != 2'b00;
  // ***************************************************************
  // shadow of settings from the register port, last strobe type from the bus
  // ***************************************************************
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {wait_ff, type_ff, share_ff, wr_ff, fin_ff} <= 13'h0000;
    end else begin
      if (reg_wr_in && reg_addr_in == `REG_AREA_WAIT) begin
        wait_ff <= reg_wdata_in[5:0];
      end
      if (reg_wr_in && reg_addr_in == `REG_AREA_ACCESS) begin
        type_ff <= reg_wdata_in[3:0];
      end
      if (reg_wr_in && reg_addr_in == `REG_TERM_CTRL) begin
        share_ff <= reg_wdata_in[7];
      end
      if (!rd_n_out || !wr_n_out) begin
        wr_ff  <= !wr_n_out;
        fin_ff <= piece_out;
      end
    end
  end
  sequence s_hold_end;
    !sel_n_out ##1 sel_n_out;
  endsequence
  property p_wo_read;
    reg_rd_in && reg_addr_in == `REG_TERM_CTRL |=> reg_rdata_out == 16'h0000;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("wo read");
  property p_hold;
    wait_ff[0] && $rose(wr_n_out) && fin_ff |-> s_hold_end;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_rd_hold;
    wait_ff[0] && $rose(rd_n_out) |-> s_hold_end;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rd hold");
  property p_no_hold;
    !wait_ff[0] && ($rose(rd_n_out) || $rose(wr_n_out)) |-> sel_n_out;
  endproperty
  a_no_hold: assert property (p_no_hold) else $error("hold");
  property p_split;
    split_w && $rose(wr_n_out) && !fin_ff |-> sel_n_out;
  endproperty
  a_split: assert property (p_split) else $error("split");
  property p_dly;
    wait_ff[2] && $fell(sel_n_out) |-> $past(addr_valid_out) && $past(sel_n_out);
  endproperty
  a_dly: assert property (p_dly) else $error("delay");
  property p_type;
    reg_rd_in && reg_addr_in == `REG_AREA_ACCESS |=> reg_rdata_out[3:0] == type_ff;
  endproperty
  a_type: assert property (p_type) else $error("type");
  property p_rec;
    wait_ff[5:4] == 2'b11 && $rose(sel_n_out) && wr_ff && fin_ff
      |-> sel_n_out [*3];
  endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  property p_grant;
    bus_grant_out |-> share_ff;
  endproperty
  a_grant: assert property (p_grant) else $error("grant");
endmodule // ext_bus_timing_sva
bind ext_bus_area_cycle_timing ext_bus_timing_sva ext_bus_timing_sva_inst (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .addr_valid_out(addr_valid_out), .sel_n_out(sel_n_out),
  .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .piece_out(piece_out),
  .bus_grant_out(bus_grant_out));

// >>> dv/testbench.sv
/* self-checking bench: random area settings and accesses, register
   readback, bus share on and off. assumes the mem model beside it. */
`timescale 1ns/1ps
`include "ext_bus_timing_defines.vh"
module testbench;
  reg ref_clk_in, nrst_in, reg_wr_in, reg_rd_in, acc_req_in, acc_write_in;
  reg acc_wide_in, bus_req_pin_in, clr;
  reg [11:0] reg_addr_in;
  reg [15:0] reg_wdata_in, v, aw;
  reg [31:0] seed;
  reg wr, wd;
  integer failures, checks, i, n;
  wire [15:0] reg_rdata_out;
  wire acc_done_out, addr_valid_out, sel_n_out, rd_n_out, wr_n_out;
  wire piece_out, bus_grant_out;
  wire [3:0] h_first, h_last, d_first, p_cnt;
  ext_bus_area_cycle_timing ext_bus_area_cycle_timing_inst (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .acc_req_in(acc_req_in), .acc_write_in(acc_write_in),
    .acc_wide_in(acc_wide_in), .acc_done_out(acc_done_out),
    .addr_valid_out(addr_valid_out), .sel_n_out(sel_n_out),
    .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .piece_out(piece_out),
    .bus_req_pin_in(bus_req_pin_in), .bus_grant_out(bus_grant_out));
  ext_bus_mem_model ext_bus_mem_model_inst (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clr_in(clr),
    .addr_valid_in(addr_valid_out), .sel_n_in(sel_n_out),
    .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .hold_first_out(h_first),
    .hold_last_out(h_last), .dly_first_out(d_first),
    .piece_cnt_out(p_cnt));
  // ***************************************************************
  // clock
  // ***************************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // hold expected per piece: hold enable, missing on a non-final split piece if delay off and recovery on
  function [15:0] exp_hold(input f, input w, input d, input [15:0] a);
    exp_hold = (f && w && d && a[0] && !a[2] && a[5:4] != 2'b00) ?
               16'h0000 : {15'h0000, a[0]};
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task reg_write(input [11:0] a, input [15:0] d);
    begin
      @(posedge ref_clk_in);
      {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, d};
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task reg_read(input [11:0] a, output [15:0] d);
    begin
      @(posedge ref_clk_in);
      {reg_rd_in, reg_addr_in} <= {1'b1, a};
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
    end
  endtask
  // one access; request held until done, bounded wait
  task access(input w, input d);
    begin
      @(posedge ref_clk_in);
      clr <= 1'b1;
      @(posedge ref_clk_in);
      clr <= 1'b0;
      {acc_req_in, acc_write_in, acc_wide_in} <= {1'b1, w, d};
      n = 0;
      while (n < 60 && acc_done_out !== 1'b1) begin
        @(posedge ref_clk_in);
        #1 n = n + 1;
      end
      acc_req_in <= 1'b0;
      if (n == 60) begin
        failures = failures + 1;
        print_verdict;
      end
    end
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, acc_req_in, acc_write_in} = 5'h00;
    {acc_wide_in, bus_req_pin_in, clr, reg_addr_in} = 15'h0000;
    {reg_wdata_in, failures, checks, seed} = {16'h0000, 64'h0, 32'h6295};
    repeat (12) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    reg_write(`REG_TERM_CTRL, 16'h0000);
    reg_read(`REG_TERM_CTRL, v);
    check(v, 16'h0000);
    reg_read(12'h3F0, v);
    check(v, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      reg_write(`REG_AREA_ACCESS, i[15:0]);
      reg_read(`REG_AREA_ACCESS, v);
      check(v, i[15:0]);
    end
    for (i = 0; i < 28; i = i + 1) begin
      seed = lfsr(seed);
      aw = {10'h000, seed[5:4], 1'b0, seed[2], 1'b0, seed[0]};
      if (i == 0) aw = 16'h0011;
      if (i == 1) aw = 16'h0015;
      if (i == 2) aw = 16'h0001;
      wr = seed[8] | (i < 3);
      wd = wr & (seed[9] | (i < 3));
      reg_write(`REG_AREA_WAIT, aw);
      reg_read(`REG_AREA_WAIT, v);
      check(v, aw);
      access(wr, wd);
      repeat (3) @(posedge ref_clk_in);
      check({12'h000, p_cnt}, wd ? 16'h0002 : 16'h0001);
      check({12'h000, h_first}, exp_hold(1'b1, wr, wd, aw));
      check({12'h000, h_last}, exp_hold(1'b0, wr, wd, aw));
      check({12'h000, d_first}, {15'h0000, aw[2]});
    end
    reg_write(`REG_PORT8_FUNC, 16'h0004);
    reg_read(`REG_PORT8_FUNC, v);
    check(v, 16'h0004);
    reg_write(`REG_TERM_CTRL, 16'h0080);
    bus_req_pin_in <= 1'b1;
    n = 0;
    while (n < 20 && bus_grant_out !== 1'b1) begin
      @(posedge ref_clk_in);
      #1 n = n + 1;
    end
    check({15'h0000, bus_grant_out}, 16'h0001);
    reg_write(`REG_PORT8_FUNC, 16'h0000);
    reg_write(`REG_TERM_CTRL, 16'h0000);
    repeat (6) @(posedge ref_clk_in);
    check({15'h0000, bus_grant_out}, 16'h0000);
    print_verdict;
  end
endmodule // testbench
